// >>> src/pulse_cmd_params.svh
// register offsets, reset values and field layout of the pulse command unit
`ifndef PULSE_CMD_PARAMS_SVH
`define PULSE_CMD_PARAMS_SVH
// printed offsets are word indices, byte address is four times index
`define IDX_GEAR_NUM      12'h158
`define IDX_GEAR_DEN      12'h15a
`define IDX_GEAR_NUM2     12'h160
`define IDX_GEAR_NUM3     12'h161
`define IDX_GEAR_NUM4     12'h162
`define IDX_PULSE_CFG     12'h100
`define IDX_STATUS        12'h170
`define IDX_POSITION      12'h171
`define RST_GEAR_NUM      32'h00000010
`define RST_GEAR_DEN      32'h0000000a
`define RST_PULSE_CFG     32'h00000002
// pulse_cfg fields
`define CFG_TYPE_LSB      0
`define CFG_LOGIC_BIT     4
`define CFG_SOURCE_BIT    8
`define CFG_SMOOTH_BIT    12
`define CFG_INH_EN_BIT    16
`define CFG_TC_LSB        20
`define REV_UNITS         10000
`endif

// >>> src/pulse_cmd_pkg.sv
// types shared by the pulse command unit
package pulse_cmd_pkg;
    typedef enum logic [1:0] {
        quadrature_type = 2'h0,
        cw_ccw_type = 2'h1,
        pulse_sign_type = 2'h2,
        reserved_type = 2'h3
    } encoding_type;
    typedef struct packed {
        logic pulse;
        logic sign;
    } pulse_pair_type;
    typedef struct packed {
        logic [31:0] pos;
        logic step;
        logic dir;
    } command_type;
endpackage

// >>> src/pulse_position_command_unit.sv
// pulse position command front end with wishbone register slave
//
// Behaviour
// - positive logic: high is one; negative logic inverts that
// - source setting 0 picks opto pair, 1 picks differential pair
// - inhibit acts only when assigned to a digital input
// - active inhibit in position mode clears command and stops motor
// - numerator writes apply at once even while servo is enabled
// - with ratio one, 10000 user position units make one revolution
// - pulse counts are multiplied by numerator over denominator
// - scaled command passes an S-curve or low-pass smoothing stage
// - four numerators, digital inputs pick one over common denominator
`timescale 1ns/1ps
`default_nettype none
`include "pulse_cmd_params.svh"

module pulse_position_command_unit #(
    parameter int DEN_MAX_W = 31,
    parameter int FILT_SHIFT_MAX = 15
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // command pins, asynchronous
    input wire pulse_cmd_pkg::pulse_pair_type low_speed_pair,
    input wire logic high_speed_pulse_input,
    input wire logic high_speed_direction_input,
    // digital inputs, asynchronous
    input wire logic pulse_command_inhibit,
    input wire logic [1:0] gear_select,
    input wire logic servo_enable_input,
    input wire logic terminal_pulse_position_mode,
    // position command out
    output pulse_cmd_pkg::command_type cmd_out,
    output logic [31:0] smooth_pos
);
    import pulse_cmd_pkg::*;

    // elaboration check: divider and filter paths are sized for 31 bits
    if (DEN_MAX_W < 2 || DEN_MAX_W > 31 || FILT_SHIFT_MAX > 31)
    begin : g_param_check
        $error("unsupported parameter value");
    end

    ////////////////////////////////////////////////////////////////////
    // synchronisers: two flops before any logic, except terminal_pulse_position_mode, which feeds inhibit_on unsynchronised
    // the two gear select bits may settle a cycle apart; a pulse edge in
    // that cycle would be scaled once by a neighbouring numerator
    logic [6:0] sync1_q, sync2_q;
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_q <= 7'h00;
            sync2_q <= 7'h00;
        end
        else
        begin
            sync1_q <= {low_speed_pair.pulse, low_speed_pair.sign,
                        high_speed_pulse_input, high_speed_direction_input,
                        pulse_command_inhibit, gear_select};
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] num_q [4];
    logic [31:0] den_q;
    logic [31:0] cfg_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] pos_q;
    logic [31:0] flt_q;
    // levels after source choice and polarity, also shown in status
    logic sel_pulse, sel_sign, logic_neg, inhibit_on;

    // byte-lane merge shared by every writable register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction

    logic [11:0] idx;
    logic req;
    assign idx = wb_adr_i[13:2];
    assign req = wb_cyc_i && wb_stb_i && !ack_q;

    // register writes; numerator takes effect immediately, even servo on
    // live numerator update
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            num_q[0] <= `RST_GEAR_NUM;
            num_q[1] <= `RST_GEAR_NUM;
            num_q[2] <= `RST_GEAR_NUM;
            num_q[3] <= `RST_GEAR_NUM;
            den_q <= `RST_GEAR_DEN;
            cfg_q <= `RST_PULSE_CFG;
        end
        // the write lands at the edge where the master sees ack high, with
        // the request still held there; one write per access
        else if (wb_cyc_i && wb_stb_i && wb_we_i && ack_q)
        begin
            unique case (idx)
                `IDX_GEAR_NUM: num_q[0] <= merge(num_q[0], wb_dat_i, wb_sel_i);
                `IDX_GEAR_NUM2: num_q[1] <= merge(num_q[1], wb_dat_i, wb_sel_i);
                `IDX_GEAR_NUM3: num_q[2] <= merge(num_q[2], wb_dat_i, wb_sel_i);
                `IDX_GEAR_NUM4: num_q[3] <= merge(num_q[3], wb_dat_i, wb_sel_i);
                `IDX_GEAR_DEN: den_q <= merge(den_q, wb_dat_i, wb_sel_i);
                `IDX_PULSE_CFG: cfg_q <= merge(cfg_q, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    // one wait state: ack is registered, so the master sees it on the
    // second edge of its request
    // ack one cycle after request, reads of unmapped offsets give zero
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= req;
            if (req)
            begin
                unique case (idx)
                    `IDX_GEAR_NUM: rdat_q <= num_q[0];
                    `IDX_GEAR_NUM2: rdat_q <= num_q[1];
                    `IDX_GEAR_NUM3: rdat_q <= num_q[2];
                    `IDX_GEAR_NUM4: rdat_q <= num_q[3];
                    `IDX_GEAR_DEN: rdat_q <= den_q;
                    `IDX_PULSE_CFG: rdat_q <= cfg_q;
                    // status: inhibit, selected sign and pulse, last direction
                    `IDX_STATUS: rdat_q <= {28'h0000000, inhibit_on,
                        sel_sign, sel_pulse, cmd_out.dir};
                    `IDX_POSITION: rdat_q <= pos_q;
                    default: rdat_q <= 32'h00000000;
                endcase
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////////////
    // source select and polarity
    encoding_type enc;
    assign enc = encoding_type'(cfg_q[`CFG_TYPE_LSB +: 2]);
    assign logic_neg = cfg_q[`CFG_LOGIC_BIT];
    always_comb
    begin
        if (cfg_q[`CFG_SOURCE_BIT])
        begin
            sel_pulse = sync2_q[4];
            sel_sign = sync2_q[3];
        end
        else
        begin
            sel_pulse = sync2_q[6];
            sel_sign = sync2_q[5];
        end
        sel_pulse = sel_pulse ^ logic_neg;
        sel_sign = sel_sign ^ logic_neg;
    end

    assign inhibit_on = cfg_q[`CFG_INH_EN_BIT] && sync2_q[2]
                        && terminal_pulse_position_mode;

    ////////////////////////////////////////////////////////////////////
    // direction decode; one count per qualifying edge
    // the last levels follow the pins even under inhibit, so releasing
    // inhibit makes no false edge
    logic p_q, s_q;
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            p_q <= 1'b0;
            s_q <= 1'b0;
        end
        else
        begin
            p_q <= sel_pulse;
            s_q <= sel_sign;
        end
    end

    logic cnt_ev, cnt_fwd;
    always_comb
    begin
        cnt_ev = 1'b0;
        cnt_fwd = 1'b0;
        unique case (enc)
            quadrature_type:
            begin
                // x4: every edge of either phase; A leading B is forward
                cnt_ev = (sel_pulse != p_q) || (sel_sign != s_q);
                if (sel_pulse != p_q)
                    cnt_fwd = (sel_pulse != sel_sign);
                else
                    cnt_fwd = (sel_pulse == sel_sign);
                if ((sel_pulse != p_q) && (sel_sign != s_q))
                    cnt_ev = 1'b0; // illegal double step is dropped
            end
            cw_ccw_type:
            begin
                // rising edge on pulse line forward, on sign line reverse
                cnt_ev = (sel_pulse && !p_q) ^ (sel_sign && !s_q);
                cnt_fwd = sel_pulse && !p_q;
            end
            pulse_sign_type:
            begin
                cnt_ev = sel_pulse && !p_q;
                cnt_fwd = sel_sign;
            end
            reserved_type:
            begin
                cnt_ev = 1'b0;
                cnt_fwd = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // electronic gear, remainder kept across pulses
    // a zero denominator gives no motion rather than a divide fault; the
    // 64-bit divide is a long path, tolerable at this clock rate
    logic [31:0] num_sel;
    logic [63:0] rem_q;
    logic [63:0] acc;
    logic [31:0] units;
    logic [63:0] rem_left;
    assign num_sel = num_q[sync2_q[1:0]];
    always_comb
    begin
        // multiply by num/den; num below den*25600 keeps units small
        acc = rem_q + {32'h00000000, num_sel};
        units = 32'h00000000;
        rem_left = acc;
        if (den_q != 32'h00000000)
        begin
            units = 32'(acc / {32'h00000000, den_q});
            rem_left = acc % {32'h00000000, den_q};
        end
    end

    // position wraps at 32 bits; long one-way runs must be rebased
    // remainder accumulation
    // position counted in user position units
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rem_q <= 64'h0;
            pos_q <= 32'h00000000;
            cmd_out <= '0;
        end
        else if (inhibit_on)
        begin
            rem_q <= 64'h0;
            pos_q <= 32'h00000000;
            cmd_out <= '0;
        end
        else
        begin
            cmd_out.step <= cnt_ev && (units != 32'h00000000);
            if (cnt_ev)
            begin
                rem_q <= rem_left;
                cmd_out.dir <= cnt_fwd;
                if (cnt_fwd)
                begin
                    pos_q <= pos_q + units;
                    cmd_out.pos <= pos_q + units;
                end
                else
                begin
                    pos_q <= pos_q - units;
                    cmd_out.pos <= pos_q - units;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // smoothing: first order low-pass, or ramp-limited S-like approach
    // a constant of zero bypasses the stage; smooth_pos then trails pos_q by one register cycle
    logic [4:0] tc;
    logic signed [32:0] err;
    assign tc = cfg_q[`CFG_TC_LSB +: 5];
    assign err = $signed({1'b0, pos_q}) - $signed({1'b0, flt_q});
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            flt_q <= 32'h00000000;
        else if (inhibit_on)
            flt_q <= 32'h00000000; // stop at once, no coasting
        else if (tc == 5'h00)
            flt_q <= pos_q;
        else if (cfg_q[`CFG_SMOOTH_BIT])
            // low-pass: step err >> tc, at least one toward target
            flt_q <= flt_q + 32'(err >>> tc) + ((err != 0 && (err >>> tc) == 0)
                     ? (err > 0 ? 32'h00000001 : 32'hffffffff) : 32'h0);
        else
            // profile: bounded step size limits rate of change
            flt_q <= flt_q + ((err > $signed({28'h0, tc}))
                     ? {27'h0, tc} : (err < -$signed({28'h0, tc}))
                     ? -{27'h0, tc} : 32'(err));
    end
    assign smooth_pos = flt_q;

endmodule // pulse_position_command_unit
`default_nettype wire

// >>> tb/pulse_cmd_asserts.sv
// port checker for the pulse command unit
`timescale 1ns/1ps
`default_nettype none
module pulse_cmd_asserts #(
    parameter int DEN_MAX_W = 31,
    parameter int FILT_SHIFT_MAX = 15
) (
    // clock, reset, bus
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins and command
    input wire pulse_cmd_pkg::pulse_pair_type low_speed_pair,
    input wire logic high_speed_pulse_input,
    input wire logic high_speed_direction_input,
    input wire pulse_cmd_pkg::command_type cmd_out
);
    import pulse_cmd_pkg::*;
    logic [3:0] pins_q;
    logic [3:0] quiet_q;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // cycles with all pins unchanged, saturating
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            {pins_q, quiet_q} <= 8'h00;
        else
        begin
            pins_q <= {low_speed_pair, high_speed_pulse_input,
                high_speed_direction_input};
            // a register write may move the selected levels with no pin edge
            if (pins_q != {low_speed_pair, high_speed_pulse_input,
                high_speed_direction_input} || (wb_cyc_i && wb_we_i))
                quiet_q <= 4'h0;
            else if (quiet_q != 4'hf)
                quiet_q <= quiet_q + 4'h1;
        end
    ////////////////////////////////////////
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_after_take: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_needs_req: assert property
        (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i == 14'h03fc |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_pos_with_step: assert property ($changed(cmd_out.pos)
        |-> cmd_out.step || cmd_out.pos == 32'h0)
        else $error("position moved without step");
    a_step_single: assert property (cmd_out.step |=> !cmd_out.step)
        else $error("step longer than a cycle");
    a_quiet_no_step: assert property
        (quiet_q > 4'h6 |-> !cmd_out.step)
        else $error("step without pin edge");
    a_quiet_pos_holds: assert property (quiet_q > 4'h7
        |-> $stable(cmd_out.pos) || cmd_out.pos == 32'h0)
        else $error("position drifts");
endmodule // pulse_cmd_asserts
bind pulse_position_command_unit pulse_cmd_asserts #(
    .DEN_MAX_W(DEN_MAX_W), .FILT_SHIFT_MAX(FILT_SHIFT_MAX)) i_chk (
    .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .low_speed_pair(low_speed_pair),
    .high_speed_pulse_input(high_speed_pulse_input),
    .high_speed_direction_input(high_speed_direction_input),
    .cmd_out(cmd_out));
`default_nettype wire

// >>> tb/motion_ctrl_model.sv
// motion controller model driving the command pins
`timescale 1ns/1ps
`default_nettype none
module motion_ctrl_model (
    // clock
    input wire logic clk,
    // command pins
    output pulse_cmd_pkg::pulse_pair_type low_speed_pair,
    output logic high_speed_pulse_input,
    output logic high_speed_direction_input
);
    import pulse_cmd_pkg::*;
    logic a_q = 1'b0, b_q = 1'b0, neg_q = 1'b0, src_q = 1'b0;
    logic busy_q = 1'b0, noise_q = 1'b0;
    logic [1:0] ph_q = 2'h0;
    // idle pair toggles while moving so a wrong choice miscounts
    always @(posedge clk)
        noise_q <= noise_q ^ busy_q;
    assign low_speed_pair = src_q ? pulse_pair_type'({noise_q, !noise_q})
        : pulse_pair_type'({a_q ^ neg_q, b_q ^ neg_q});
    assign high_speed_pulse_input = src_q ? a_q ^ neg_q : noise_q;
    assign high_speed_direction_input = src_q ? b_q ^ neg_q : !noise_q;
    // pins held three cycles, above the two that the unit needs
    task automatic edge_to(input logic a, input logic b);
        repeat (3) @(posedge clk);
        a_q <= a;
        b_q <= b;
    endtask
    task automatic setup(input logic neg, input logic src);
        @(posedge clk);
        {neg_q, src_q, a_q, b_q, ph_q} <= {neg, src, 4'h0};
    endtask
    // phase order, active line or sign level
    task automatic move(input encoding_type enc, input int n,
        input logic fwd);
        logic [1:0] p;
        logic cw;
        p = ph_q;
        cw = enc == cw_ccw_type;
        busy_q <= 1'b1;
        if (enc == pulse_sign_type)
            edge_to(1'b0, fwd);
        for (int i = 0; i < n; i++)
        begin
            if (enc == quadrature_type)
            begin
                p = fwd ? p + 2'h1 : p - 2'h1;
                edge_to(p[0] ^ p[1], p[1]);
            end
            else
            begin
                edge_to(cw ? fwd : 1'b1, cw ? !fwd : fwd);
                edge_to(1'b0, cw ? 1'b0 : fwd);
            end
        end
        ph_q <= p;
        repeat (8) @(posedge clk);
        busy_q <= 1'b0;
    endtask
endmodule // motion_ctrl_model
`default_nettype wire

// >>> tb/pulse_position_command_unit_tb.sv
// self-checking bench for the pulse command unit
`timescale 1ns/1ps
`default_nettype none
module pulse_position_command_unit_tb;
    import pulse_cmd_pkg::*;
    localparam logic [13:0] A_NUM = 14'h0560;
    localparam logic [13:0] A_DEN = 14'h0568;
    localparam logic [13:0] A_CFG = 14'h0400;
    localparam logic [13:0] A_POS = 14'h05c4;
    logic sys_clk = 1'b0, rstn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0, wb_ack_o, hs_pulse, hs_dir;
    logic inhibit = 1'b0, servo_on = 1'b0, pos_mode = 1'b1;
    logic [1:0] gear_sel = 2'h0;
    logic [13:0] wb_adr_i = 14'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, smooth_pos, pos, cfg;
    pulse_pair_type ls_pair;
    command_type cmd_out;
    logic [31:0] exp_q[$];
    int error_cnt = 0, checked = 0;
    always #20 sys_clk = ~sys_clk;
    pulse_position_command_unit i_dut (.sys_clk(sys_clk), .rstn(rstn),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .low_speed_pair(ls_pair),
        .high_speed_pulse_input(hs_pulse), .high_speed_direction_input(hs_dir),
        .pulse_command_inhibit(inhibit), .gear_select(gear_sel),
        .servo_enable_input(servo_on),
        .terminal_pulse_position_mode(pos_mode),
        .cmd_out(cmd_out), .smooth_pos(smooth_pos));
    motion_ctrl_model i_host (.clk(sys_clk), .low_speed_pair(ls_pair),
        .high_speed_pulse_input(hs_pulse), .high_speed_direction_input(hs_dir));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // request held until ack is sampled, then released; only the
    // watchdog ends a wait that never gets its answer
    task automatic wb(input logic we, input logic [13:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, 4'hf};
        {wb_adr_i, wb_dat_i} <= {a, d};
        do
            @(posedge sys_clk);
        while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    task automatic rd(input logic [13:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic clear;
        inhibit <= 1'b1;
        repeat (6) @(posedge sys_clk);
        inhibit <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask
    // oldest note against each read answer
    always @(posedge sys_clk)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
            chk(exp_q.pop_front(), wb_dat_o);
    // watchdog at 40000 cycles, far beyond the thousand or so cycles needed
    initial
    begin
        #(40 * 40000);
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        logic [1:0] enc;
        logic src;
        int n;
        void'($urandom(32'he216));
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(A_NUM, 32'h10);
        rd(A_DEN, 32'ha);
        for (int i = 0; i < 3; i++)
            rd(14'h0580 + 14'(4 * i), 32'h10);
        rd(A_CFG, 32'h2);
        wb(1'b1, 14'h03fc, 32'hffffffff);
        rd(14'h03fc, 32'h0);
        // ratio one over quadrature, cw/ccw and pulse-sign, both polarities and a random pair
        wb(1'b1, A_DEN, 32'h1);
        wb(1'b1, A_NUM, 32'h1);
        for (int k = 0; k < 6; k++)
        begin
            enc = 2'(k % 3);
            src = 1'($urandom);
            cfg = 32'h10000 | 32'(enc) | 32'(k < 3) << 4 | 32'(src) << 8
                | ($urandom & 32'h01f01000);
            wb(1'b1, A_CFG, cfg);
            i_host.setup(k < 3, src);
            clear();
            i_host.move(encoding_type'(enc), 5, 1'b1);
            i_host.move(encoding_type'(enc), 2, 1'b0);
            chk(32'h0, 32'(cmd_out.dir));
            rd(A_POS, 32'h3);
        end
        wb(1'b1, A_CFG, cfg & ~32'h10000);
        clear();
        rd(A_POS, 32'h3);
        // inhibit outside position mode leaves the command alone
        wb(1'b1, A_CFG, cfg);
        pos_mode <= 1'b0;
        clear();
        rd(A_POS, 32'h3);
        pos_mode <= 1'b1;
        clear();
        rd(A_POS, 32'h0);
        wb(1'b1, A_DEN, 32'h3);
        i_host.move(encoding_type'(enc), 7, 1'b1);
        rd(A_POS, 32'h2);
        i_host.move(encoding_type'(enc), 2, 1'b1);
        rd(A_POS, 32'h3);
        wb(1'b1, A_DEN, 32'h1);
        servo_on <= 1'b1;
        pos = 32'h3;
        for (int g = 0; g < 4; g++)
        begin
            n = 1 + $urandom % 4;
            gear_sel <= 2'(g);
            wb(1'b1, g == 0 ? A_NUM : 14'h057c + 14'(4 * g),
                32'(g + 2));
            i_host.move(encoding_type'(enc), n, 1'b1);
            pos += 32'(n * (g + 2));
            rd(A_POS, pos);
            chk(pos, cmd_out.pos);
            // the smoothed value must settle on the command
            repeat (40) @(posedge sys_clk);
            chk(pos, smooth_pos);
        end
        report_and_stop();
    end
endmodule // pulse_position_command_unit_tb
`default_nettype wire
